// file: src/kvm_map.vh
// Register map, key codes and state constants of the keypad monitor
`ifndef KVM_MAP_VH
`define KVM_MAP_VH
// ============================================================
// Register indices; byte address is four times the index
`define KVM_IDX_MASK 14'h0B02
`define KVM_IDX_TIME 14'h0B03
`define KVM_IDX_TOGGLE 14'h0B04
`define KVM_IDX_LANG 14'h0B05
`define KVM_IDX_STATUS 14'h0B06
`define KVM_ADDR_W 16
// ============================================================
// Reset values
`define KVM_MASK_RST 8'hFF
`define KVM_TIME_RST 16'h0023
`define KVM_TOGGLE_RST 1'b0
`define KVM_LANG_RST 1'b0
// Display time unit in milliseconds (one tick pulse)
`define KVM_TICK_MS 100
// ============================================================
// Enable mask bit positions
`define KVM_EN_REG 0
`define KVM_EN_FLAG 1
`define KVM_EN_OUT 2
`define KVM_EN_IN 3
`define KVM_EN_WREG 4
`define KVM_EN_WFLAG 5
`define KVM_EN_WOUT 6
`define KVM_EN_PERM 7
// ============================================================
// Key codes; 5'h00 to 5'h09 are the digits
`define KVM_KEY_DIGMAX 5'h09
`define KVM_KEY_REG 5'h0A
`define KVM_KEY_IO 5'h0B
`define KVM_KEY_ASSIGN 5'h0C
`define KVM_KEY_ENTER 5'h0D
`define KVM_KEY_CLEAR 5'h0E
// ============================================================
// Variable types
`define KVM_T_REG 2'h0
`define KVM_T_FLAG 2'h1
`define KVM_T_OUT 2'h2
`define KVM_T_IN 2'h3
// ============================================================
// States
`define KVM_S_IDLE 2'h0
`define KVM_S_SEL 2'h1
`define KVM_S_SHOW 2'h2
`define KVM_S_VALUE 2'h3
// Status register fields
`define KVM_ST_TIMER_LSB 16
`endif

// file: src/kvm_monitor.v
// Keypad monitor command interpreter with APB register file
`timescale 1ns/10ps
`default_nettype none
`include "kvm_map.vh"
// Contract
// R01 - Type keys start monitor, re-select until ENTER
// R02 - One register key, number, ENTER: register
// R03 - Two register or three I/O presses: flag
// R04 - One I/O press, number, ENTER: output
// R05 - Two I/O presses, number, ENTER: input
// R06 - Monitor screen timed, then default screen
// R07 - Assign key enters value, ENTER writes it
// R08 - ENTER during display returns to default
// R09 - ENTER on default reshows last variable
// R10 - Mask eight bits, resets ones, bit0 register
// R11 - Mask bits 1-3 gate flag, output, input
// R12 - Mask bits 4-6 gate value writes
// R13 - Mask bit 7 gates permanent input display
// R14 - Disabled function keys go to key flags
// R15 - Display time 16 bits, 100 ms, resets 35
// R16 - New display time applies at next entry
// R17 - Toggle control 1 disables ENTER switching
// R18 - Language latched at next monitor launch
// R19 - Consumed keys not passed to key flags
// R20 - Timer loads, counts ticks, zero returns
// R21 - Single-cycle key strobes, odd codes ignored
module kvm_monitor (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`KVM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Operator panel keys and timebase
  input wire key_valid,
  input wire [4:0] key_code,
  input wire tick_100ms,
  // Monitor screen control
  output reg screen_monitor,
  output reg [1:0] var_type,
  output reg [31:0] var_number,
  output reg value_entry,
  output reg perm_display,
  output reg language,
  // Variable write request
  output reg write_strobe,
  output reg [31:0] write_value,
  // Keys handed on to the ordinary key flags
  output reg key_flag_valid,
  output reg [4:0] key_flag_code
);

  // ============================================================
  // Registers and state
  reg [7:0] monitor_enable_mask; // Function enables
  reg [15:0] monitor_display_time; // Duration in ticks
  reg screen_toggle_disable; // ENTER switching lock
  reg dialog_language_select; // 0 German, 1 English
  reg [1:0] state; // Interpreter state
  reg [1:0] sel_count; // Presses of the current type key
  reg sel_is_io; // Last type key was the I/O key
  reg [31:0] num_acc; // Digit accumulator
  reg [15:0] timer; // Display countdown
  reg have_last; // A variable has been shown
  reg [1:0] next_state;
  reg [1:0] next_type;
  reg next_consume;
  reg next_write;
  reg next_load;
  reg next_perm;
  reg next_launch;
  reg [1:0] next_count;
  reg next_is_io;

  // ============================================================
  // Key decode
  wire is_digit = key_valid && (key_code <= `KVM_KEY_DIGMAX);
  wire is_reg = key_valid && (key_code == `KVM_KEY_REG);
  wire is_io = key_valid && (key_code == `KVM_KEY_IO);
  wire is_asg = key_valid && (key_code == `KVM_KEY_ASSIGN);
  wire is_ent = key_valid && (key_code == `KVM_KEY_ENTER);
  wire is_clr = key_valid && (key_code == `KVM_KEY_CLEAR);
  // Register key cannot launch when its own enable is off, flags included;
  // flags then need the I/O key to launch, after which register presses still count
  wire reg_ok = monitor_enable_mask[`KVM_EN_REG]; // R10
  // I/O key can start if any of flag, output, input display is on
  wire io_ok = monitor_enable_mask[`KVM_EN_FLAG] |
    monitor_enable_mask[`KVM_EN_OUT] |
    monitor_enable_mask[`KVM_EN_IN]; // R11

  // Type chosen by the press sequence
  reg [1:0] seq_type;
  always @*
  begin
    seq_type = `KVM_T_REG;
    if (!sel_is_io)
      seq_type = (sel_count == 2'h2) ? `KVM_T_FLAG : `KVM_T_REG; // R02 R03
    else if (sel_count == 2'h1)
      seq_type = `KVM_T_OUT; // R04
    else if (sel_count == 2'h2)
      seq_type = `KVM_T_IN; // R05
    else
      seq_type = `KVM_T_FLAG; // R03
  end

  // Display enable of the selected type
  reg show_en;
  always @*
  begin
    case (seq_type)
      `KVM_T_REG: show_en = monitor_enable_mask[`KVM_EN_REG]; // R10
      `KVM_T_FLAG: show_en = monitor_enable_mask[`KVM_EN_FLAG]; // R11
      `KVM_T_OUT: show_en = monitor_enable_mask[`KVM_EN_OUT]; // R11
      default: show_en = monitor_enable_mask[`KVM_EN_IN]; // R11
    endcase
  end

  // Write enable of the displayed type; input means permanent view
  reg asg_en;
  always @*
  begin
    case (var_type)
      `KVM_T_REG: asg_en = monitor_enable_mask[`KVM_EN_WREG]; // R12
      `KVM_T_FLAG: asg_en = monitor_enable_mask[`KVM_EN_WFLAG]; // R12
      `KVM_T_OUT: asg_en = monitor_enable_mask[`KVM_EN_WOUT]; // R12
      default: asg_en = monitor_enable_mask[`KVM_EN_PERM]; // R13
    endcase
  end

  // ============================================================
  // Interpreter next-state logic
  always @*
  begin
    next_state = state;
    next_type = var_type;
    next_consume = 1'b0;
    next_write = 1'b0;
    next_load = 1'b0;
    next_perm = perm_display;
    next_launch = 1'b0;
    next_count = sel_count;
    next_is_io = sel_is_io;
    case (state)
      `KVM_S_IDLE:
      begin
        // Default screen; type keys launch, ENTER reshows
        if ((is_reg && reg_ok) || (is_io && io_ok))
        begin
          next_state = `KVM_S_SEL; // R01
          next_count = 2'h1;
          next_is_io = is_io;
          next_launch = 1'b1; // R18
          next_consume = 1'b1; // R19
        end
        else if (is_ent && have_last && !screen_toggle_disable)
        begin
          next_state = `KVM_S_SHOW; // R09 R17
          next_load = 1'b1;
          next_consume = 1'b1;
        end
      end
      `KVM_S_SEL:
      begin
        next_consume = key_valid; // R19
        if (is_reg || is_io)
        begin
          // Same key counts up, other key restarts the count
          if (is_io == sel_is_io)
            next_count = (sel_count == (is_io ? 2'h3 : 2'h2)) ?
              2'h1 : sel_count + 2'h1; // R01
          else
            next_count = 2'h1; // R01
          next_is_io = is_io;
        end
        else if (is_ent)
        begin
          if (show_en)
          begin
            next_state = `KVM_S_SHOW; // R02 R03 R04 R05
            next_type = seq_type;
            next_load = 1'b1;
            next_perm = 1'b0;
          end
          else
            next_state = `KVM_S_IDLE; // R11
        end
        else if (is_clr)
          next_state = `KVM_S_IDLE;
      end
      `KVM_S_SHOW:
      begin
        next_consume = key_valid; // R19
        if (is_ent)
        begin
          // Early return only when switching is allowed
          if (!screen_toggle_disable)
          begin
            next_state = `KVM_S_IDLE; // R08 R17
            next_perm = 1'b0;
          end
        end
        else if (is_clr)
        begin
          next_state = `KVM_S_IDLE;
          next_perm = 1'b0;
        end
        else if (is_asg)
        begin
          if (!asg_en)
            next_consume = 1'b0; // R14
          else if (var_type == `KVM_T_IN)
            next_perm = 1'b1; // R13
          else
            next_state = `KVM_S_VALUE; // R07
        end
        else if (!perm_display && timer == 16'h0000)
          next_state = `KVM_S_IDLE; // R06 R20
      end
      `KVM_S_VALUE:
      begin
        next_consume = key_valid; // R19
        if (is_ent)
        begin
          next_write = 1'b1; // R07
          next_state = `KVM_S_SHOW;
          next_load = 1'b1;
        end
        else if (is_clr)
          next_state = `KVM_S_IDLE;
      end
      default: next_state = `KVM_S_IDLE;
    endcase
    // A timer already at zero with no key also ends the display
    if (state == `KVM_S_SHOW && !key_valid && !perm_display &&
        timer == 16'h0000)
      next_state = `KVM_S_IDLE; // R20
  end

  // ============================================================
  // Interpreter state, timer and outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= `KVM_S_IDLE;
      sel_count <= 2'h0;
      sel_is_io <= 1'b0;
      num_acc <= 32'h00000000;
      timer <= 16'h0000;
      have_last <= 1'b0;
      var_type <= `KVM_T_REG;
      var_number <= 32'h00000000;
      screen_monitor <= 1'b0;
      value_entry <= 1'b0;
      perm_display <= 1'b0;
      language <= `KVM_LANG_RST;
      write_strobe <= 1'b0;
      write_value <= 32'h00000000;
      key_flag_valid <= 1'b0;
      key_flag_code <= 5'h00;
    end
    else
    begin
      state <= next_state;
      sel_count <= next_count;
      sel_is_io <= next_is_io;
      var_type <= next_type;
      perm_display <= next_perm;
      // Decimal accumulation; overflow wraps, parsing is outside
      if ((state == `KVM_S_SEL || state == `KVM_S_VALUE) && is_digit)
        num_acc <= num_acc * 32'h0000000A + {27'h0000000, key_code};
      else if (next_state != state || is_clr || is_asg)
        num_acc <= 32'h00000000;
      // Variable number fixed when ENTER selects it
      if (state == `KVM_S_SEL && next_state == `KVM_S_SHOW)
      begin
        var_number <= num_acc;
        have_last <= 1'b1;
      end
      // Language picked up only at launch
      if (next_launch)
        language <= dialog_language_select; // R18
      // Timer reloads from the current setting on each entry
      if (next_load)
        timer <= monitor_display_time; // R16 R20
      else if (state == `KVM_S_SHOW && tick_100ms &&
               timer != 16'h0000)
        timer <= timer - 16'h0001; // R20
      screen_monitor <= (next_state == `KVM_S_SHOW) ||
        (next_state == `KVM_S_VALUE);
      value_entry <= (next_state == `KVM_S_VALUE); // R07
      write_strobe <= next_write; // R07
      if (next_write)
        write_value <= num_acc;
      // Unused keys are handed on one cycle later
      key_flag_valid <= key_valid && !next_consume; // R14 R19 R21
      if (key_valid && !next_consume)
        key_flag_code <= key_code;
    end
  end

  // ============================================================
  // APB slave; zero wait states, error on unmapped index
  wire [`KVM_ADDR_W-3:0] idx = paddr[`KVM_ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready;
  reg hit;
  reg [31:0] rd_mux;
  always @*
  begin
    hit = aligned;
    rd_mux = 32'h00000000;
    case (idx)
      `KVM_IDX_MASK: rd_mux = {24'h000000, monitor_enable_mask};
      `KVM_IDX_TIME: rd_mux = {16'h0000, monitor_display_time};
      `KVM_IDX_TOGGLE: rd_mux = {31'h00000000, screen_toggle_disable};
      `KVM_IDX_LANG: rd_mux = {31'h00000000, dialog_language_select};
      `KVM_IDX_STATUS:
        rd_mux = {timer, 11'h000, perm_display, var_type, state};
      default: hit = 1'b0;
    endcase
  end

  // Read data and error are latched in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata <= (hit && !pwrite) ? rd_mux : 32'h00000000;
        pslverr <= !hit || (pwrite && idx == `KVM_IDX_STATUS);
      end
    end
  end

  // Configuration registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      monitor_enable_mask <= `KVM_MASK_RST; // R10
      monitor_display_time <= `KVM_TIME_RST; // R15
      screen_toggle_disable <= `KVM_TOGGLE_RST;
      dialog_language_select <= `KVM_LANG_RST;
    end
    else if (wr_acc && !pslverr)
    begin
      case (idx)
        `KVM_IDX_MASK: monitor_enable_mask <= pwdata[7:0]; // R10
        `KVM_IDX_TIME: monitor_display_time <= pwdata[15:0]; // R15
        `KVM_IDX_TOGGLE: screen_toggle_disable <= pwdata[0]; // R17
        `KVM_IDX_LANG: dialog_language_select <= pwdata[0]; // R18
        default: ;
      endcase
    end
  end

endmodule // kvm_monitor
`default_nettype wire

// file: verif/keypad_variable_monitor_bench.sv
// Self-checking bench for the keypad monitor
`timescale 1ns/10ps
`default_nettype none
`include "kvm_map.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
// ==========
// Bench
module keypad_variable_monitor_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, write_value, var_number, got, e;
  logic pready, pslverr, key_valid, tick_100ms, screen_monitor;
  logic value_entry, perm_display, language, write_strobe, key_flag_valid;
  logic [4:0] key_code, key_flag_code;
  logic [1:0] var_type;
  logic [31:0] q[$];
  int n_mismatch = 0, n_compared = 0, seed = 92258, d;
  // Type-key table: key, presses, resulting type
  logic [4:0] tk[5] = '{5'h0A, 5'h0A, 5'h0B, 5'h0B, 5'h0B};
  int tn[5] = '{1, 2, 1, 2, 3};
  logic [1:0] tt[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  always #20 pclk = ~pclk;
  kvm_monitor DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_valid(key_valid), .key_code(key_code), .tick_100ms(tick_100ms),
    .screen_monitor(screen_monitor), .var_type(var_type),
    .var_number(var_number), .value_entry(value_entry),
    .perm_display(perm_display), .language(language),
    .write_strobe(write_strobe), .write_value(write_value),
    .key_flag_valid(key_flag_valid), .key_flag_code(key_flag_code));
  kvm_panel #(.TICK_CYC(8)) panel (.pclk(pclk), .presetn(presetn),
    .key_valid(key_valid), .key_code(key_code), .tick_100ms(tick_100ms));
  // Results matched in order against the oldest note
  always @(posedge pclk)
  begin
    if (presetn && (psel && penable && pready && !pwrite || write_strobe ||
      key_flag_valid))
    begin
      e = q.size() ? q.pop_front() : 32'hFFFFFFFF;
      got = write_strobe ? write_value : key_flag_valid ?
        {27'h0, key_flag_code} : prdata;
      `CHK(got, e)
    end
  end
  // APB transfer; a read notes its word
  task apb(input logic w, input logic [13:0] idx, input logic [31:0] v);
    @(posedge pclk);
    if (!w) q.push_back(v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Type key n times, a digit, ENTER
  task pick(input logic [4:0] k, input int n, input logic [4:0] dg);
    repeat (n) panel.press(k);
    panel.press(dg);
    panel.press(`KVM_KEY_ENTER);
    @(posedge pclk);
    #1;
  endtask
  // Key then one settled cycle
  task hit(input logic [4:0] k);
    panel.press(k);
    @(posedge pclk);
    #1;
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `KVM_IDX_MASK, 32'hFF);
    apb(0, `KVM_IDX_TIME, 32'h23);
    apb(0, `KVM_IDX_TOGGLE, 0);
    apb(0, `KVM_IDX_LANG, 0);
    apb(0, 14'h0000, 0);
    $display("reset values done");
    apb(1, `KVM_IDX_TIME, 3);
    apb(1, `KVM_IDX_LANG, 1);
    d = $unsigned($random(seed)) % 10;
    pick(`KVM_KEY_REG, 1, d[4:0]);
    `CHK(var_number, d)
    `CHK(language, 1'b1)
    apb(1, `KVM_IDX_TIME, 50);
    apb(0, `KVM_IDX_TIME, 50);
    apb(1, `KVM_IDX_LANG, 0);
    #1;
    `CHK(screen_monitor, 1'b1)
    `CHK(language, 1'b1)
    repeat (60) if (screen_monitor === 1'b1) @(posedge pclk);
    #1;
    `CHK(screen_monitor, 1'b0)
    apb(1, `KVM_IDX_TIME, 20);
    $display("timed display done");
    for (int i = 0; i < 5; i++)
    begin
      pick(tk[i], tn[i], 5'h01);
      `CHK(var_type, tt[i])
      hit(`KVM_KEY_ENTER);
      `CHK(screen_monitor, 1'b0)
    end
    `CHK(language, 1'b0)
    panel.press(`KVM_KEY_IO);
    pick(`KVM_KEY_REG, 1, 5'h02);
    `CHK(var_type, `KVM_T_REG)
    hit(`KVM_KEY_ENTER);
    hit(`KVM_KEY_ENTER);
    `CHK(screen_monitor, 1'b1)
    hit(`KVM_KEY_ENTER);
    apb(1, `KVM_IDX_TOGGLE, 1);
    q.push_back(`KVM_KEY_ENTER);
    hit(`KVM_KEY_ENTER);
    `CHK(screen_monitor, 1'b0)
    apb(1, `KVM_IDX_TOGGLE, 0);
    $display("type keys done");
    pick(`KVM_KEY_REG, 1, 5'h07);
    hit(5'h03);
    hit(`KVM_KEY_ASSIGN);
    `CHK(value_entry, 1'b1)
    panel.press(5'h04);
    panel.press(5'h02);
    q.push_back(32'd42);
    hit(`KVM_KEY_ENTER);
    `CHK(screen_monitor, 1'b1)
    hit(`KVM_KEY_ENTER);
    apb(1, `KVM_IDX_MASK, 32'hEF);
    pick(`KVM_KEY_REG, 1, 5'h07);
    q.push_back(`KVM_KEY_ASSIGN);
    hit(`KVM_KEY_ASSIGN);
    `CHK(value_entry, 1'b0)
    hit(`KVM_KEY_ENTER);
    apb(1, `KVM_IDX_MASK, 32'hFE);
    q.push_back(`KVM_KEY_REG);
    hit(`KVM_KEY_REG);
    apb(1, `KVM_IDX_MASK, 32'hF7);
    pick(`KVM_KEY_IO, 2, 5'h01);
    `CHK(screen_monitor, 1'b0)
    apb(1, `KVM_IDX_MASK, 32'hFF);
    pick(`KVM_KEY_IO, 2, 5'h03);
    hit(`KVM_KEY_ASSIGN);
    `CHK(perm_display, 1'b1)
    hit(`KVM_KEY_ENTER);
    pick(`KVM_KEY_REG, 1, 5'h05);
    hit(`KVM_KEY_CLEAR);
    `CHK(screen_monitor, 1'b0)
    `CHK(q.size(), 0)
    $display("write and mask done");
    end_of_test;
  end
endmodule // keypad_variable_monitor_bench
`default_nettype wire

// file: verif/kvm_monitor_sva.sv
// Port checker for the keypad monitor
`timescale 1ns/10ps
`default_nettype none
`include "kvm_map.vh"
// ==========
// Checker
module kvm_monitor_sva (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`KVM_ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Keys and screen
  input wire logic key_valid,
  input wire logic [4:0] key_code,
  input wire logic screen_monitor,
  input wire logic value_entry,
  input wire logic perm_display,
  input wire logic write_strobe,
  input wire logic key_flag_valid,
  input wire logic [4:0] key_flag_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ENTER key taken at this edge
  wire enter_k = key_valid && key_code == `KVM_KEY_ENTER;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmap; psel && !penable && paddr == 16'h0000 |=> pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no slave error");
  property p_wpulse; write_strobe |=> !write_strobe; endproperty
  a_wpulse: assert property (p_wpulse) else $error("long strobe");
  property p_wcause; write_strobe |-> $past(value_entry) && $past(enter_k);
  endproperty
  a_wcause: assert property (p_wcause) else $error("stray write");
  property p_write; value_entry && enter_k |=> write_strobe && screen_monitor;
  endproperty
  a_write: assert property (p_write) else $error("write lost");
  property p_entry; value_entry |-> screen_monitor; endproperty
  a_entry: assert property (p_entry) else $error("value hidden");
  property p_echo;
    key_flag_valid |-> $past(key_valid) && key_flag_code == $past(key_code);
  endproperty
  a_echo: assert property (p_echo) else $error("bad key flag");
  property p_consume; screen_monitor && key_valid &&
    key_code <= `KVM_KEY_DIGMAX |=> !key_flag_valid; endproperty
  a_consume: assert property (p_consume) else $error("digit leaked");
  // Assign on an input display may make it permanent instead
  property p_assign; screen_monitor && !value_entry && !perm_display &&
    key_valid && key_code == `KVM_KEY_ASSIGN |=>
    (value_entry || perm_display) != key_flag_valid; endproperty
  a_assign: assert property (p_assign) else $error("assign lost");
  c_write: cover property (write_strobe);
  c_flag: cover property (key_flag_valid);
  c_exit: cover property ($fell(screen_monitor));
  c_perm: cover property ($rose(perm_display));
endmodule // kvm_monitor_sva
bind kvm_monitor kvm_monitor_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .key_valid(key_valid), .key_code(key_code),
  .screen_monitor(screen_monitor), .value_entry(value_entry),
  .perm_display(perm_display),
  .write_strobe(write_strobe), .key_flag_valid(key_flag_valid),
  .key_flag_code(key_flag_code));
`default_nettype wire

// file: verif/kvm_panel.sv
// Operator panel model: key strobes and the 100 ms tick
`timescale 1ns/10ps
`default_nettype none
// ==========
// Panel
module kvm_panel #(parameter int TICK_CYC = 8) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Keypad and timebase
  output var logic key_valid,
  output var logic [4:0] key_code,
  output var logic tick_100ms
);
  int cnt = 0;
  initial key_valid = 1'b0;
  initial key_code = 5'h1F;
  initial tick_100ms = 1'b0;
  // Tick shortened to keep runs brief
  always @(posedge pclk)
  begin
    if (!presetn)
      cnt <= 0;
    else
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
    tick_100ms <= presetn && (cnt == TICK_CYC - 1);
  end
  // One stroke; the stale code is scrambled
  task press(input logic [4:0] c);
    @(posedge pclk);
    key_valid <= 1'b1;
    key_code <= c;
    @(posedge pclk);
    key_valid <= 1'b0;
    key_code <= ~c;
  endtask
endmodule // kvm_panel
`default_nettype wire
